// ### hw/fcd_pkg.sv
// shared constants and types for the four-channel cycle-steal transfer engine
package fcd_pkg;
    localparam int NCH = 4;
    localparam int ADDR_W = 24;
    localparam int CNT_W = 16;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int SEL_W = 5;
    localparam int REG_W = 32;
    localparam int RA_W = 8;

    // register address layout: byte address = {0, ch[1:0], idx[2:0], 00}
    localparam int RA_TOP = 7;
    localparam int RA_CH_LSB = 5;
    localparam int RA_IDX_LSB = 2;
    localparam int RA_CH_W = 2;
    localparam int RA_IDX_W = 3;
    localparam logic [1:0] RA_ALIGN = 2'h0;

    // register indices within a channel
    localparam logic [2:0] REG_SEL = 3'h0;
    localparam logic [2:0] REG_MODE = 3'h1;
    localparam logic [2:0] REG_CNT = 3'h2;
    localparam logic [2:0] REG_RLC = 3'h3;
    localparam logic [2:0] REG_MADR = 3'h4;
    localparam logic [2:0] REG_FADR = 3'h5;
    localparam logic [2:0] REG_RADR = 3'h6;
    localparam logic [2:0] REG_STAT = 3'h7;

    // source_select_register fields
    localparam int SEL_LSB = 0;
    localparam int SEL_SWREQ = 5;
    localparam int SEL_PEND = 7;
    // channel_mode_register fields
    localparam int MODE_LSB = 0;
    localparam int MODE_UNIT = 2;
    localparam int MODE_DIR = 3;
    // status fields
    localparam int STAT_RUN = 0;
    localparam int STAT_BUSY = 1;
    localparam int STAT_PEND = 2;

    // transfer_mode_field codes
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_SINGLE = 2'h1;
    localparam logic [1:0] MODE_REPEAT = 2'h3;

    // request_source_select codes
    localparam logic [4:0] SRC_SW = 5'h00;
    localparam logic [4:0] SRC_PIN_FALL = 5'h01;
    localparam logic [4:0] SRC_PIN_BOTH = 5'h02;
    localparam logic [4:0] SRC_TA0 = 5'h03;
    localparam logic [4:0] SRC_TB0 = 5'h08;
    localparam logic [4:0] SRC_UART0 = 5'h0e;
    localparam logic [4:0] SRC_ADC = 5'h18;
    localparam logic [4:0] SRC_IIO0 = 5'h19;
    localparam logic [3:0] IIO_NONE = 4'hf;

    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [ADDR_W-1:0] STEP8 = 24'h000001;
    localparam logic [ADDR_W-1:0] STEP16 = 24'h000002;
    localparam logic [3:0] PIN_IDLE = 4'hf;

    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_LATCH, ST_WRITE} fcd_state_t;
endpackage

// ### hw/fcd_dma.sv
// four-channel cycle-steal transfer engine with register port and bus master
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
// Operation
// - four channels, one stolen cycle group each
// - channel 0 wins, then 1, 2, 3
// - one 8 or 16 bit unit per request
// - one fixed side, one advancing memory side
// - 16-bit counter limits run length
// - engine takes bus ahead of core
// - start by software bit or selected event
// - interrupt enable state never blocks requests
// - peripheral request flags left untouched
// - single mode decrements, stops at zero
// - repeat mode reloads count and address
// - end interrupt only on one to zero
// - start needs count nonzero, mode 01/11
// - mode 00 or zero count stops channel
// - selector codes for pins and timers
// - selector codes for serial units, converter
// - per-channel map for high selector codes
// - transfer takes at least three cycles
// - direction bit picks source and destination
// - zero count means no transfer
module fcd_dma
    import fcd_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // register port
    input wire logic [RA_W-1:0] reg_addr_in,
    input wire logic [REG_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [REG_W-1:0] reg_rdata_out,
    // peripheral request pulses, same clock
    input wire logic [4:0] ta_req_in,
    input wire logic [5:0] tb_req_in,
    input wire logic [4:0] uart_tx_req_in,
    input wire logic [4:0] uart_rx_req_in,
    input wire logic adc_req_in,
    input wire logic [10:0] iio_req_in,
    input wire logic can2_req_in,
    // external_request_pin per channel, asynchronous
    input wire logic [NCH-1:0] external_request_pin_in,
    // shared bus master
    output logic bus_req_out,
    output logic [ADDR_W-1:0] mem_addr_out,
    output logic mem_rd_out,
    output logic mem_wr_out,
    output logic mem_word_out,
    output logic [DATA_W-1:0] mem_wdata_out,
    input wire logic [DATA_W-1:0] mem_rdata_in,
    // end-of-transfer requests
    output logic [NCH-1:0] done_irq_out
);

    typedef struct packed {
        fcd_state_t st;
        logic [RA_CH_W-1:0] act;
        logic [NCH-1:0][SEL_W-1:0] sel;
        logic [NCH-1:0][1:0] mode;
        logic [NCH-1:0] unit16;
        logic [NCH-1:0] dir;
        logic [NCH-1:0] pend;
        logic [NCH-1:0][CNT_W-1:0] cnt;
        logic [NCH-1:0][CNT_W-1:0] rlc;
        logic [NCH-1:0][ADDR_W-1:0] madr;
        logic [NCH-1:0][ADDR_W-1:0] fadr;
        logic [NCH-1:0][ADDR_W-1:0] radr;
        logic [NCH-1:0] s1;
        logic [NCH-1:0] s2;
        logic [NCH-1:0] s3;
        logic [NCH-1:0] filt;
        logic breq;
        logic mrd;
        logic mwr;
        logic mword;
        logic [ADDR_W-1:0] maddr;
        logic [DATA_W-1:0] mwdata;
        logic [NCH-1:0] done;
        logic [REG_W-1:0] rdata;
    } fcd_regs_t;

    fcd_regs_t r;
    fcd_regs_t next_r;
    logic [NCH-1:0] elig;
    logic [NCH-1:0] ev;
    logic [NCH-1:0] pin_fall;
    logic [NCH-1:0] pin_both;
    logic [NCH-1:0] next_filt;
    logic [11:0] iiox;

    // channel may run: valid mode and nonzero count
    function automatic logic fcd_runnable(input logic [1:0] md, input logic [CNT_W-1:0] ct);
        return ((md == MODE_SINGLE) || (md == MODE_REPEAT)) && (ct != CNT_ZERO);
    endfunction

    // lowest index wins
    function automatic logic [RA_CH_W-1:0] fcd_pick(input logic [NCH-1:0] v);
        logic [RA_CH_W-1:0] p;
        p = '0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (v[i]) begin
                p = RA_CH_W'(i);
            end
        end
        return p;
    endfunction

    // channel-specific upper selector table; index 11 is the can2 request
    function automatic logic [3:0] fcd_iio_map(input logic [1:0] ch, input logic [4:0] code);
        logic [3:0] p;
        p = IIO_NONE;
        case ({ch, code})
            {2'h0, 5'h19}: p = 4'h0;
            {2'h0, 5'h1a}: p = 4'h1;
            {2'h0, 5'h1b}: p = 4'h2;
            {2'h0, 5'h1c}: p = 4'h3;
            {2'h0, 5'h1d}: p = 4'h4;
            {2'h1, 5'h1a}: p = 4'h8;
            {2'h1, 5'h1b}: p = 4'h9;
            {2'h1, 5'h1c}: p = 4'ha;
            {2'h1, 5'h1d}: p = 4'hb;
            {2'h1, 5'h1e}: p = 4'h0;
            {2'h1, 5'h1f}: p = 4'h1;
            {2'h2, 5'h19}: p = 4'h2;
            {2'h2, 5'h1a}: p = 4'h3;
            {2'h2, 5'h1b}: p = 4'h4;
            {2'h2, 5'h1f}: p = 4'h8;
            {2'h3, 5'h19}: p = 4'h9;
            {2'h3, 5'h1a}: p = 4'ha;
            {2'h3, 5'h1b}: p = 4'hb;
            {2'h3, 5'h1c}: p = 4'h0;
            {2'h3, 5'h1d}: p = 4'h1;
            {2'h3, 5'h1e}: p = 4'h2;
            {2'h3, 5'h1f}: p = 4'h3;
            default: p = IIO_NONE;
        endcase
        return p;
    endfunction

    // selected peripheral event for one channel
    function automatic logic fcd_src_hit(input logic [1:0] ch, input logic [4:0] code,
                                         input logic fall, input logic both,
                                         input logic [4:0] ta, input logic [5:0] tb,
                                         input logic [4:0] utx, input logic [4:0] urx,
                                         input logic adc, input logic [11:0] ix);
        logic hit;
        logic [4:0] off;
        logic [3:0] p;
        hit = 1'b0;
        off = '0;
        p = fcd_iio_map(ch, code);
        if (code == SRC_PIN_FALL) begin
            hit = fall;
        end else if (code == SRC_PIN_BOTH) begin
            hit = both;
        end else if ((code >= SRC_TA0) && (code < SRC_TB0)) begin
            off = code - SRC_TA0;
            hit = ta[off[2:0]];
        end else if ((code >= SRC_TB0) && (code < SRC_UART0)) begin
            off = code - SRC_TB0;
            hit = tb[off[2:0]];
        end else if ((code >= SRC_UART0) && (code < SRC_ADC)) begin
            off = code - SRC_UART0;
            hit = off[0] ? urx[off[3:1]] : utx[off[3:1]];
        end else if (code == SRC_ADC) begin
            hit = adc;
        end else if ((code >= SRC_IIO0) && (p != IIO_NONE)) begin
            hit = ix[p];
        end
        return hit;
    endfunction

    assign iiox = {can2_req_in, iio_req_in};

    always_comb begin
        logic [RA_CH_W-1:0] a;
        logic [RA_CH_W-1:0] wc;
        logic [RA_IDX_W-1:0] wi;
        logic mapped;
        a = r.act;
        wc = reg_addr_in[RA_CH_LSB +: RA_CH_W];
        wi = reg_addr_in[RA_IDX_LSB +: RA_IDX_W];
        mapped = !reg_addr_in[RA_TOP] && (reg_addr_in[1:0] == RA_ALIGN);
        next_r = r;
        next_r.done = '0;
        next_r.rdata = '0;
        next_r.mrd = 1'b0;
        next_r.mwr = 1'b0;
        // pin filter: a change counts once stages two and three agree
        next_r.s1 = external_request_pin_in;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        for (int c = 0; c < NCH; c++) begin
            next_filt[c] = (r.s2[c] == r.s3[c]) ? r.s3[c] : r.filt[c];
        end
        next_r.filt = next_filt;
        pin_fall = r.filt & ~next_filt;
        pin_both = r.filt ^ next_filt;
        // request sources; interrupt enables play no part and flags are never cleared here
        for (int c = 0; c < NCH; c++) begin
            ev[c] = fcd_src_hit(RA_CH_W'(c), r.sel[c], pin_fall[c], pin_both[c], ta_req_in, tb_req_in,
                                uart_tx_req_in, uart_rx_req_in, adc_req_in, iiox);
            elig[c] = r.pend[c] && fcd_runnable(r.mode[c], r.cnt[c]);
        end
        case (r.st)
            ST_IDLE: begin
                if (|elig) begin
                    a = fcd_pick(elig);
                    next_r.act = a;
                    next_r.pend[a] = 1'b0;
                    next_r.st = ST_READ;
                    next_r.breq = 1'b1;
                    next_r.mrd = 1'b1;
                    next_r.mword = r.unit16[a];
                    next_r.maddr = r.dir[a] ? r.madr[a] : r.fadr[a];
                end else begin
                    next_r.breq = 1'b0;
                end
            end
            ST_READ: begin
                next_r.st = ST_LATCH;
            end
            ST_LATCH: begin
                next_r.st = ST_WRITE;
                next_r.mwr = 1'b1;
                next_r.maddr = r.dir[a] ? r.fadr[a] : r.madr[a];
                next_r.mwdata = r.unit16[a] ? mem_rdata_in : {{BYTE_W{1'b0}}, mem_rdata_in[BYTE_W-1:0]};
            end
            ST_WRITE: begin
                // bus handed back for at least one cycle after each unit
                next_r.st = ST_IDLE;
                next_r.breq = 1'b0;
                next_r.madr[a] = r.madr[a] + (r.unit16[a] ? STEP16 : STEP8);
                next_r.cnt[a] = r.cnt[a] - CNT_ONE;
                if (r.cnt[a] == CNT_ONE) begin
                    next_r.done[a] = 1'b1;
                    if (r.mode[a] == MODE_REPEAT) begin
                        next_r.cnt[a] = r.rlc[a];
                        next_r.madr[a] = r.radr[a];
                    end
                end
            end
            default: begin
                next_r.st = ST_IDLE;
                next_r.breq = 1'b0;
            end
        endcase
        // a new request wins over the grant that clears pending
        next_r.pend = next_r.pend | ev;
        if (reg_wr_in && mapped) begin
            case (wi)
                REG_SEL: begin
                    next_r.sel[wc] = reg_wdata_in[SEL_LSB +: SEL_W];
                    if (reg_wdata_in[SEL_SWREQ] || reg_wdata_in[SEL_PEND]) begin
                        next_r.pend[wc] = 1'b1;
                    end
                end
                REG_MODE: begin
                    next_r.mode[wc] = reg_wdata_in[MODE_LSB +: 2];
                    next_r.unit16[wc] = reg_wdata_in[MODE_UNIT];
                    next_r.dir[wc] = reg_wdata_in[MODE_DIR];
                end
                REG_CNT: next_r.cnt[wc] = reg_wdata_in[CNT_W-1:0];
                REG_RLC: next_r.rlc[wc] = reg_wdata_in[CNT_W-1:0];
                REG_MADR: next_r.madr[wc] = reg_wdata_in[ADDR_W-1:0];
                REG_FADR: next_r.fadr[wc] = reg_wdata_in[ADDR_W-1:0];
                REG_RADR: next_r.radr[wc] = reg_wdata_in[ADDR_W-1:0];
                default: next_r.sel[wc] = next_r.sel[wc];
            endcase
        end
        if (reg_rd_in && mapped) begin
            case (wi)
                REG_SEL: begin
                    next_r.rdata[SEL_LSB +: SEL_W] = r.sel[wc];
                    next_r.rdata[SEL_PEND] = r.pend[wc];
                end
                REG_MODE: begin
                    next_r.rdata[MODE_LSB +: 2] = r.mode[wc];
                    next_r.rdata[MODE_UNIT] = r.unit16[wc];
                    next_r.rdata[MODE_DIR] = r.dir[wc];
                end
                REG_CNT: next_r.rdata[CNT_W-1:0] = r.cnt[wc];
                REG_RLC: next_r.rdata[CNT_W-1:0] = r.rlc[wc];
                REG_MADR: next_r.rdata[ADDR_W-1:0] = r.madr[wc];
                REG_FADR: next_r.rdata[ADDR_W-1:0] = r.fadr[wc];
                REG_RADR: next_r.rdata[ADDR_W-1:0] = r.radr[wc];
                default: begin
                    next_r.rdata[STAT_RUN] = fcd_runnable(r.mode[wc], r.cnt[wc]);
                    next_r.rdata[STAT_BUSY] = (r.st != ST_IDLE) && (r.act == wc);
                    next_r.rdata[STAT_PEND] = r.pend[wc];
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            r <= '0;
            r.s1 <= PIN_IDLE;
            r.s2 <= PIN_IDLE;
            r.s3 <= PIN_IDLE;
            r.filt <= PIN_IDLE;
        end else begin
            r <= next_r;
        end
    end

    assign reg_rdata_out = r.rdata;
    assign bus_req_out = r.breq;
    assign mem_addr_out = r.maddr;
    assign mem_rd_out = r.mrd;
    assign mem_wr_out = r.mwr;
    assign mem_word_out = r.mword;
    assign mem_wdata_out = r.mwdata;
    assign done_irq_out = r.done;

    // helper views of the active channel
    logic [CNT_W-1:0] cnt_act;
    logic [CNT_W-1:0] rlc_act;
    logic [ADDR_W-1:0] madr_act;
    assign cnt_act = r.cnt[r.act];
    assign rlc_act = r.rlc[r.act];
    assign madr_act = r.madr[r.act];

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    steal_gap_a: assert property (bus_req_out [*3] |=> !bus_req_out) else $error("bus held too long");
    prio_zero_a: assert property (r.st == ST_IDLE && elig[0] |=> r.act == 2'h0 && mem_rd_out)
        else $error("channel 0 not first");
    xfer_len_a: assert property ($rose(mem_rd_out) |-> ##2 mem_wr_out) else $error("transfer not three cycles");
    bus_first_a: assert property (mem_rd_out || mem_wr_out |-> bus_req_out) else $error("bus used without hold");
    start_ok_a: assert property ($rose(mem_rd_out) && !$past(reg_wr_in) |-> cnt_act != CNT_ZERO)
        else $error("transfer with zero count");
    src_side_a: assert property ($rose(mem_rd_out) && !$past(reg_wr_in) |->
        mem_addr_out == (r.dir[r.act] ? madr_act : r.fadr[r.act])) else $error("wrong source address");
    unit_size_a: assert property (mem_wr_out |-> mem_word_out == r.unit16[r.act]) else $error("unit mismatch");
    mem_step_a: assert property (r.st == ST_WRITE && cnt_act != CNT_ONE && !reg_wr_in |=>
        madr_act == $past(madr_act) + (r.unit16[r.act] ? STEP16 : STEP8)) else $error("bad pointer step");
    single_stop_a: assert property (r.st == ST_WRITE && cnt_act == CNT_ONE && r.mode[r.act] == MODE_SINGLE
        && !reg_wr_in |=> cnt_act == CNT_ZERO ##1 !(mem_rd_out && r.act == $past(r.act)))
        else $error("single did not stop");
    reload_cnt_a: assert property (r.st == ST_WRITE && cnt_act == CNT_ONE && r.mode[r.act] == MODE_REPEAT
        && !reg_wr_in |=> cnt_act == $past(rlc_act)) else $error("no reload");
    end_irq_a: assert property (|done_irq_out |-> $past(r.st) == ST_WRITE && $past(cnt_act) == CNT_ONE)
        else $error("end interrupt out of place");

    // destination, mode and fixed side of the unit in flight, channel 1 order, one-cycle end pulse
    dst_side_a: assert property (mem_wr_out && !$past(reg_wr_in) |->
        mem_addr_out == (r.dir[r.act] ? r.fadr[r.act] : madr_act)) else $error("wrong destination address");
    run_mode_a: assert property ($rose(mem_rd_out) && !$past(reg_wr_in) |->
        r.mode[r.act] == MODE_SINGLE || r.mode[r.act] == MODE_REPEAT) else $error("transfer while disabled");
    fixed_keep_a: assert property (r.st == ST_WRITE && !reg_wr_in |=>
        r.fadr[r.act] == $past(r.fadr[r.act])) else $error("fixed address moved");
    prio_one_a: assert property (r.st == ST_IDLE && elig[1] && !elig[0] |=>
        r.act == 2'h1 && mem_rd_out) else $error("channel 1 not second");
    done_pulse_a: assert property (|done_irq_out |=>
        done_irq_out == '0) else $error("end interrupt held");

    // main scenarios
    single_end_c: cover property (|done_irq_out && r.mode[r.act] == MODE_SINGLE);
    repeat_end_c: cover property (|done_irq_out && r.mode[r.act] == MODE_REPEAT);
    two_pend_c: cover property (r.st == ST_IDLE && elig[0] && elig[3]);
    pin_edge_c: cover property (r.st == ST_IDLE && |pin_fall);
    word_move_c: cover property (mem_wr_out && mem_word_out);
endmodule

// ### verif/fcd_mem_model.sv
// memory and peripheral register model on the shared bus
`timescale 1ns/10ps
module fcd_mem_model
    import fcd_pkg::*;
(
    // clock
    input wire logic clk_in,
    // bus from the engine
    input wire logic [ADDR_W-1:0] mem_addr_in,
    input wire logic mem_rd_in,
    // read data back to the engine
    output logic [DATA_W-1:0] mem_rdata_out
);
    initial mem_rdata_out = 16'h0000;
    // data stand only in the cycle after the strobe; a released bus keeps toggling
    always @(posedge clk_in) begin
        if (mem_rd_in) begin
            mem_rdata_out <= mem_addr_in[15:0] ^ 16'h5a3c;
        end else begin
            mem_rdata_out <= ~mem_rdata_out;
        end
    end
endmodule

// ### verif/tb.sv
// self-checking bench for the four-channel transfer engine
`timescale 1ns/10ps
module tb
    import fcd_pkg::*;
;
    logic clk_in, nrst_in, reg_wr_in, reg_rd_in, adc_req_in, can2_req_in;
    logic [RA_W-1:0] reg_addr_in;
    logic [REG_W-1:0] reg_wdata_in, reg_rdata_out;
    logic [4:0] ta_req_in, uart_tx_req_in, uart_rx_req_in;
    logic [5:0] tb_req_in;
    logic [10:0] iio_req_in;
    logic [NCH-1:0] external_request_pin_in, done_irq_out;
    logic bus_req_out, mem_rd_out, mem_wr_out, mem_word_out, wr_word;
    logic [ADDR_W-1:0] mem_addr_out, rd_addr;
    logic [DATA_W-1:0] mem_wdata_out, mem_rdata_in, wr_data;
    logic [ADDR_W-1:0] wlog [$];
    int done_cnt [NCH] = '{default: 0};
    int cyc = 0;
    int rd_cyc = 0;
    int fails = 0;
    int num_checks = 0;

    fcd_dma i_dut (.clk_in(clk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .ta_req_in(ta_req_in),
        .tb_req_in(tb_req_in), .uart_tx_req_in(uart_tx_req_in), .uart_rx_req_in(uart_rx_req_in),
        .adc_req_in(adc_req_in), .iio_req_in(iio_req_in), .can2_req_in(can2_req_in),
        .external_request_pin_in(external_request_pin_in), .bus_req_out(bus_req_out), .mem_addr_out(mem_addr_out),
        .mem_rd_out(mem_rd_out), .mem_wr_out(mem_wr_out), .mem_word_out(mem_word_out),
        .mem_wdata_out(mem_wdata_out), .mem_rdata_in(mem_rdata_in), .done_irq_out(done_irq_out));
    fcd_mem_model i_mem (.clk_in(clk_in), .mem_addr_in(mem_addr_out), .mem_rd_in(mem_rd_out),
        .mem_rdata_out(mem_rdata_in));

    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // bus watcher: logs every unit written and its timing
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (mem_rd_out) begin
            rd_addr <= mem_addr_out;
            rd_cyc <= cyc;
        end
        if (mem_wr_out) begin
            wlog.push_back(mem_addr_out);
            wr_data <= mem_wdata_out;
            wr_word <= mem_word_out;
            check({31'h0, bus_req_out}, 32'h1);
            check(32'(cyc - rd_cyc), 32'h2);
        end
        for (int i = 0; i < NCH; i++) begin
            if (done_irq_out[i]) done_cnt[i] <= done_cnt[i] + 1;
        end
    end

    function automatic logic [7:0] ra(input logic [1:0] ch, input logic [2:0] idx);
        return {1'b0, ch, idx, RA_ALIGN};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1;
        check(reg_rdata_out, e);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    task automatic wait_wr(input int n);
        int t;
        t = 0;
        while (wlog.size() < n && t < 60) begin
            @(posedge clk_in);
            t++;
        end
        check(32'(wlog.size()), 32'(n));
        @(posedge clk_in);
        #1;
    endtask

    task automatic pulse(input int k);
        @(posedge clk_in);
        if (k >= 3 && k <= 7) ta_req_in[k-3] <= 1'b1;
        else if (k >= 8 && k <= 13) tb_req_in[k-8] <= 1'b1;
        else if (k >= 14 && k <= 23 && k % 2 == 0) uart_tx_req_in[(k-14)/2] <= 1'b1;
        else if (k >= 14 && k <= 23) uart_rx_req_in[(k-14)/2] <= 1'b1;
        else if (k == 24) adc_req_in <= 1'b1;
        else iio_req_in[0] <= 1'b1;
        @(posedge clk_in);
        ta_req_in <= 5'h00;
        tb_req_in <= 6'h00;
        uart_tx_req_in <= 5'h00;
        uart_rx_req_in <= 5'h00;
        adc_req_in <= 1'b0;
        iio_req_in <= 11'h000;
    endtask

    task automatic t_reset();
        #1;
        check({28'h0, bus_req_out, mem_rd_out, mem_wr_out, |done_irq_out}, 32'h0);
        for (int c = 0; c < NCH; c++) begin
            for (int i = 0; i < 8; i++) rd(ra(2'(c), 3'(i)), 32'h0);
        end
        rd(8'h80, 32'h0);
        rd(8'h05, 32'h0);
        wr(ra(1, REG_STAT), 32'hffffffff);
        rd(ra(1, REG_STAT), 32'h0);
        $display("test reset done");
    endtask

    task automatic t_single();
        wr(ra(0, REG_FADR), 32'h123456);
        wr(ra(0, REG_MADR), 32'h000100);
        wr(ra(0, REG_CNT), 32'h2);
        wr(ra(0, REG_MODE), 32'h1);
        wr(ra(0, REG_SEL), 32'ha0);
        wait_wr(1);
        check(rd_addr, 32'h123456);
        check(wlog[0], 32'h000100);
        check({wr_word, wr_data}, {8'h00, 8'h56 ^ 8'h3c});
        rd(ra(0, REG_MADR), 32'h000101);
        rd(ra(0, REG_CNT), 32'h1);
        check(32'(done_cnt[0]), 32'h0);
        wr(ra(0, REG_SEL), 32'ha0);
        wait_wr(2);
        check(32'(done_cnt[0]), 32'h1);
        rd(ra(0, REG_CNT), 32'h0);
        wr(ra(0, REG_SEL), 32'ha0);
        settle(10);
        check(32'(wlog.size()), 32'h2);
        rd(ra(0, REG_STAT), 32'h4);
        $display("test single done");
    endtask

    task automatic t_prio();
        // three channels busy: no fast interrupt path is used here
        for (int c = 2; c < 4; c++) begin
            wr(ra(2'(c), REG_SEL), 32'h98);
            wr(ra(2'(c), REG_MADR), 32'(c * 32'h1100));
            wr(ra(2'(c), REG_MODE), 32'h1);
        end
        @(posedge clk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= ra(0, REG_CNT);
        reg_wdata_in <= 32'h1;
        @(posedge clk_in);
        reg_addr_in <= ra(3, REG_CNT);
        @(posedge clk_in);
        reg_addr_in <= ra(2, REG_CNT);
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
        wait_wr(5);
        check(wlog[2], 32'h000102);
        check(wlog[3], 32'h002200);
        check(wlog[4], 32'h003300);
        check(32'(done_cnt[2] + done_cnt[3]), 32'h2);
        $display("test priority done");
    endtask

    task automatic t_repeat();
        wr(ra(1, REG_SEL), 32'h83);
        wr(ra(1, REG_FADR), 32'h00abcd);
        wr(ra(1, REG_MADR), 32'h000200);
        wr(ra(1, REG_RADR), 32'h000200);
        wr(ra(1, REG_RLC), 32'h2);
        wr(ra(1, REG_CNT), 32'h2);
        wr(ra(1, REG_MODE), 32'hf);
        wait_wr(6);
        check(rd_addr, 32'h000200);
        check(wlog[5], 32'h00abcd);
        check({wr_word, wr_data}, {1'b1, 16'h0200 ^ 16'h5a3c});
        rd(ra(1, REG_MADR), 32'h000202);
        pulse(3);
        wait_wr(7);
        check(rd_addr, 32'h000202);
        check(32'(done_cnt[1]), 32'h1);
        rd(ra(1, REG_CNT), 32'h2);
        rd(ra(1, REG_MADR), 32'h000200);
        wr(ra(1, REG_CNT), 32'h0);
        rd(ra(1, REG_STAT), 32'h0);
        wr(ra(1, REG_MODE), 32'h2);
        wr(ra(1, REG_CNT), 32'h1);
        pulse(3);
        settle(10);
        check(32'(wlog.size()), 32'h7);
        rd(ra(1, REG_STAT), 32'h4);
        $display("test repeat done");
    endtask

    task automatic t_sources();
        for (int k = 3; k <= 25; k++) begin
            wr(ra(0, REG_MODE), 32'h0);
            wr(ra(0, REG_SEL), 32'h80 | 32'(k));
            wr(ra(0, REG_CNT), 32'h2);
            wr(ra(0, REG_MODE), 32'h1);
            settle(8);
            pulse(k == 24 ? 3 : 24);
            settle(8);
            rd(ra(0, REG_CNT), 32'h1);
            pulse(k);
            settle(8);
            rd(ra(0, REG_CNT), 32'h0);
        end
        $display("test sources done");
    endtask

    task automatic t_pins();
        for (int m = 1; m <= 2; m++) begin
            wr(ra(0, REG_MODE), 32'h0);
            wr(ra(0, REG_SEL), 32'h80 | 32'(m));
            wr(ra(0, REG_CNT), 32'h3);
            wr(ra(0, REG_MODE), 32'h1);
            settle(8);
            external_request_pin_in[0] <= 1'b0;
            settle(10);
            rd(ra(0, REG_CNT), 32'h1);
            external_request_pin_in[0] <= 1'b1;
            settle(10);
            rd(ra(0, REG_CNT), 32'(2 - m));
        end
        $display("test pins done");
    endtask

    initial begin
        #(20000 * 100);
        fails++;
        close_out();
    end

    initial begin
        nrst_in = 1'b0;
        reg_addr_in = 8'h00;
        reg_wdata_in = 32'h0;
        reg_wr_in = 1'b0;
        reg_rd_in = 1'b0;
        ta_req_in = 5'h00;
        tb_req_in = 6'h00;
        uart_tx_req_in = 5'h00;
        uart_rx_req_in = 5'h00;
        adc_req_in = 1'b0;
        iio_req_in = 11'h000;
        can2_req_in = 1'b0;
        external_request_pin_in = PIN_IDLE;
        repeat (2) @(posedge clk_in);
        nrst_in <= 1'b1;
        t_reset();
        t_single();
        t_prio();
        t_repeat();
        t_sources();
        t_pins();
        close_out();
    end
endmodule
